// ### hw/i2cseq_pkg.sv
// =====================================================================
// shared constants of the transfer sequencer
package i2cseq_pkg;

	// =================================================================
	// register byte offsets on the avalon slave
	localparam logic [4:0] OFS_CONTROL_ONE = 5'h00;
	localparam logic [4:0] OFS_CONTROL_TWO = 5'h04;
	localparam logic [4:0] OFS_OWN_ADDRESS = 5'h08;
	localparam logic [4:0] OFS_DATA_BUFFER = 5'h0c;
	localparam logic [4:0] OFS_BUS_STATUS  = 5'h10;

	// =================================================================
	// field positions
	localparam int CR1_BC_LSB  = 5;
	localparam int CR1_ACK_BIT = 4;
	localparam int CR1_SCK_LSB = 0;
	localparam int CR2_MST_BIT = 7;
	localparam int CR2_TRX_BIT = 6;
	localparam int CR2_BB_BIT  = 5;
	localparam int CR2_PIN_BIT = 4;
	localparam int CR2_SBIM_LSB = 2;
	localparam int AR_SA_LSB   = 1;
	localparam int AR_ALS_BIT  = 0;

	// =================================================================
	// reset values and codes
	localparam logic [2:0] RST_BC    = 3'h0;
	localparam logic [2:0] RST_SCK   = 3'h0;
	localparam logic       RST_ACK   = 1'b0;
	localparam logic       RST_PIN   = 1'b1;
	localparam logic [1:0] RST_SBIM  = 2'h0;
	localparam logic [6:0] RST_SA    = 7'h00;
	localparam logic       RST_ALS   = 1'b0;
	localparam logic [1:0] SBIM_I2C  = 2'h2;
	localparam logic [3:0] CMD_START = 4'hf;
	localparam logic [3:0] CMD_STOP  = 4'hd;
	localparam logic [3:0] ADDR_CLOCKS = 4'h9;
	localparam logic [3:0] FULL_WORD   = 4'h8;

	// =================================================================
	// timing: half scl period is base cycles shifted left by the divider
	localparam int SCL_HALF_BASE_CYC = 16;

	typedef enum logic [2:0] {
		M_IDLE  = 3'b000,
		M_START = 3'b001,
		M_LOW   = 3'b010,
		M_HIGH  = 3'b011,
		M_WAIT  = 3'b100,
		M_STOP1 = 3'b101,
		M_STOP2 = 3'b110
	} i2cseq_mstate_t;

endpackage

// ### hw/i2cseq_linesync.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// line synchroniser and condition detector
module i2cseq_linesync (
	input  wire logic clk,       // system clock
	input  wire logic rst,       // synchronous reset
	input  wire logic scl_i,     // raw scl level
	input  wire logic sda_i,     // raw sda level
	output logic      scl_s,     // synchronised scl
	output logic      sda_s,     // synchronised sda
	output logic      scl_rise,  // scl rose
	output logic      scl_fall,  // scl fell
	output logic      start_det, // start condition seen
	output logic      stop_det   // stop condition seen
);
	typedef struct packed {
		logic scl_m, sda_m;
		logic scl_q, sda_q;
		logic scl_d, sda_d;
	} i2cseq_sync_t;

	i2cseq_sync_t s, next_s;

	always_comb begin
		next_s = s;
		// first stage feeds only the second
		next_s.scl_m = scl_i;
		next_s.sda_m = sda_i;
		next_s.scl_q = s.scl_m;
		next_s.sda_q = s.sda_m;
		next_s.scl_d = s.scl_q;
		next_s.sda_d = s.sda_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '1;
		end else begin
			s <= next_s;
		end
	end

	assign scl_s     = s.scl_q;
	assign sda_s     = s.sda_q;
	assign scl_rise  = s.scl_q & ~s.scl_d;
	assign scl_fall  = ~s.scl_q & s.scl_d;
	assign start_det = s.scl_q & s.scl_d & s.sda_d & ~s.sda_q;
	assign stop_det  = s.scl_q & s.scl_d & ~s.sda_d & s.sda_q;
endmodule // i2cseq_linesync
`default_nettype wire

// ### hw/i2cseq_top.sv
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module i2cseq_top
	import i2cseq_pkg::*;
#(
	parameter int SCL_HALF_BASE = SCL_HALF_BASE_CYC
) (
	input  wire logic        CLK,          // system clock
	input  wire logic        SYS_RST,      // synchronous reset
	input  wire logic [4:0]  ADDRESS,      // avalon byte address
	input  wire logic        READ,         // avalon read
	input  wire logic        WRITE,        // avalon write
	input  wire logic [31:0] WRITEDATA,    // avalon write data
	output logic      [31:0] READDATA,     // avalon read data
	output logic             WAITREQUEST,  // avalon wait
	input  wire logic        SCL_I,        // scl line level
	output logic             SCL_O,        // scl drive value
	output logic             SCL_OE,       // scl pulled low
	input  wire logic        SDA_I,        // sda line level
	output logic             SDA_O,        // sda drive value
	output logic             SDA_OE,       // sda pulled low
	output logic             TRANSFER_IRQ  // word end pulse
);
	typedef struct packed {
		logic           wait_req;
		logic [31:0]    rdata;
		logic           ack_en;
		logic [2:0]     bc;
		logic [2:0]     sck;
		logic [6:0]     sa;
		logic           address_recognition_off;
		logic           master_select, trx, bb, pin;
		logic [1:0]     sbim;
		logic           aas, ad0, lrb;
		logic [7:0]     shift;
		logic [7:0]     rx;
		logic           start_req, stop_req, addr_phase, addr_dir;
		i2cseq_mstate_t mstate;
		logic [3:0]     bit_cnt;
		logic [15:0]    tcnt;
		logic           sl_active;
		logic [3:0]     sl_cnt;
		logic [7:0]     sl_shift;
		logic           sl_ack, sl_hold;
		logic           scl_oe, sda_oe, irq;
	} i2cseq_state_t;

	i2cseq_state_t s, next_s;

	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

	// =================================================================
	// line sampling
	i2cseq_linesync u_sync (
		.clk       (CLK),
		.rst       (SYS_RST),
		.scl_i     (SCL_I),
		.sda_i     (SDA_I),
		.scl_s     (scl_s),
		.sda_s     (sda_s),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// =================================================================
	// helpers
	// zero means eight
	function automatic logic [3:0] word_bits(input logic [2:0] bc);
		word_bits = (bc == 3'h0) ? FULL_WORD : {1'b0, bc};
	endfunction

	function automatic logic [15:0] half_cycles(input logic [2:0] sck);
		half_cycles = 16'(SCL_HALF_BASE) << sck;
	endfunction

	logic        en, tx_mode, tdone, bus_req, acc_rd, acc_wr;
	logic [3:0]  nbits, total;

	assign en      = (s.sbim == SBIM_I2C);
	assign tx_mode = s.addr_phase | s.trx;
	assign nbits   = s.addr_phase ? FULL_WORD : word_bits(s.bc);
	assign total   = s.addr_phase ? ADDR_CLOCKS : nbits + {3'h0, s.ack_en};
	assign tdone   = (s.tcnt >= half_cycles(s.sck) - 16'h0001);
	assign bus_req = READ | WRITE;
	assign acc_rd  = READ & ~s.wait_req;
	assign acc_wr  = WRITE & ~s.wait_req;

	always_comb begin
		logic aas_set;
		aas_set = 1'b0;
		next_s = s;
		next_s.irq = 1'b0;
		next_s.tcnt = s.tcnt + 16'h0001;

		// =============================================================
		// avalon: one wait cycle, data ready when wait drops
		next_s.wait_req = ~(bus_req & s.wait_req);
		if (READ && s.wait_req) begin
			unique case (ADDRESS)
				OFS_CONTROL_ONE: next_s.rdata = {24'h0, s.bc, s.ack_en, 1'b0, s.sck};
				OFS_CONTROL_TWO: next_s.rdata = {24'h0, s.master_select, s.trx, s.bb, s.pin,
					s.sbim, 2'h0};
				OFS_OWN_ADDRESS: next_s.rdata = {24'h0, s.sa, s.address_recognition_off};
				// rx holds stale shift after address
				OFS_DATA_BUFFER: next_s.rdata = {24'h0, s.rx};
				OFS_BUS_STATUS:  next_s.rdata = {24'h0, s.master_select, s.trx, s.bb, s.pin,
					1'b0, s.aas, s.ad0, s.lrb};
				default:         next_s.rdata = 32'h0;
			endcase
		end

		// =============================================================
		// bus conditions
		// busy tracks start and stop
		if (start_det) begin
			next_s.bb = 1'b1;
			next_s.ad0 = 1'b0;
		end
		if (stop_det) begin
			next_s.bb = 1'b0;
			next_s.master_select = 1'b0;
			next_s.trx = 1'b0;
			next_s.ad0 = 1'b0;
		end

		// =============================================================
		// master engine
		unique case (s.mstate)
			M_IDLE: begin
				next_s.tcnt = 16'h0;
				if (s.start_req && en) begin
					next_s.start_req = 1'b0;
					next_s.mstate = M_START;
					next_s.sda_oe = 1'b1;
					next_s.addr_phase = 1'b1;
					next_s.addr_dir = s.shift[0];
					next_s.bit_cnt = 4'h0;
				end
			end
			M_START: begin
				if (tdone) begin
					next_s.mstate = M_LOW;
					next_s.scl_oe = 1'b1;
					next_s.tcnt = 16'h0;
				end
			end
			M_LOW: begin
				next_s.scl_oe = 1'b1;
				if (s.bit_cnt < nbits) begin
					next_s.sda_oe = tx_mode & ~s.shift[7];
				end else begin
					next_s.sda_oe = ~tx_mode;
				end
				if (tdone) begin
					next_s.mstate = M_HIGH;
					next_s.scl_oe = 1'b0;
					next_s.tcnt = 16'h0;
				end
			end
			M_HIGH: begin
				// slow slaves may stretch the high phase
				if (!scl_s) begin
					next_s.tcnt = 16'h0;
				end else if (tdone) begin
					next_s.lrb = sda_s;
					if (s.bit_cnt < nbits) begin
						next_s.shift = tx_mode ? {s.shift[6:0], 1'b0} : {s.shift[6:0], sda_s};
					end
					next_s.bit_cnt = s.bit_cnt + 4'h1;
					next_s.scl_oe = 1'b1;
					next_s.tcnt = 16'h0;
					next_s.mstate = M_LOW;
					if (s.bit_cnt + 4'h1 == total) begin
						// word end: interrupt, clear pending, hold low
						next_s.irq = 1'b1;
						next_s.pin = 1'b0;
						next_s.mstate = M_WAIT;
						next_s.rx = next_s.shift;
						next_s.addr_phase = 1'b0;
						if (s.addr_phase && !sda_s) begin
							next_s.trx = ~s.addr_dir;
						end
					end
				end
			end
			M_WAIT: begin
				next_s.scl_oe = 1'b1;
				next_s.sda_oe = 1'b0;
				next_s.tcnt = 16'h0;
				if (s.stop_req) begin
					next_s.mstate = M_STOP1;
					next_s.sda_oe = 1'b1;
				end else if (s.pin) begin
					next_s.mstate = M_LOW;
					next_s.bit_cnt = 4'h0;
				end
			end
			M_STOP1: begin
				if (tdone) begin
					next_s.mstate = M_STOP2;
					next_s.scl_oe = 1'b0;
					next_s.tcnt = 16'h0;
				end
			end
			M_STOP2: begin
				if (!scl_s) begin
					next_s.tcnt = 16'h0;
				end else if (tdone) begin
					next_s.sda_oe = 1'b0;
					next_s.stop_req = 1'b0;
					next_s.mstate = M_IDLE;
				end
			end
			default: next_s.mstate = M_IDLE;
		endcase

		// =============================================================
		// slave address reception
		if (en && !s.master_select && s.mstate == M_IDLE) begin
			// count rises, so the fall closing the start is no bit
			if (s.sl_active && scl_rise) begin
				next_s.sl_cnt = s.sl_cnt + 4'h1;
				if (s.sl_cnt < FULL_WORD) begin
					next_s.sl_shift = {s.sl_shift[6:0], sda_s};
				end
			end
			if (s.sl_active && scl_fall) begin
				if (s.sl_cnt == FULL_WORD) begin
					if (!s.address_recognition_off && (s.sl_shift[7:1] == s.sa || s.sl_shift == 8'h00)) begin
						next_s.sl_ack = 1'b1;
						next_s.sda_oe = 1'b1;
						next_s.aas = 1'b1;
						aas_set = 1'b1;
						next_s.ad0 = (s.sl_shift == 8'h00);
						next_s.trx = s.sl_shift[0];
					end else begin
						next_s.sl_active = 1'b0;
					end
				end else if (s.sl_cnt == ADDR_CLOCKS) begin
					next_s.sl_ack = 1'b0;
					next_s.sda_oe = 1'b0;
					next_s.irq = 1'b1;
					next_s.pin = 1'b0;
					next_s.sl_hold = 1'b1;
					next_s.scl_oe = 1'b1;
					next_s.sl_active = 1'b0;
				end
			end
			if (start_det) begin
				next_s.sl_active = 1'b1;
				next_s.sl_cnt = 4'h0;
			end
			if (stop_det) begin
				next_s.sl_active = 1'b0;
				next_s.sl_ack = 1'b0;
				next_s.sda_oe = 1'b0;
			end
		end
		if (s.sl_hold && s.pin) begin
			next_s.sl_hold = 1'b0;
			next_s.scl_oe = 1'b0;
		end

		// =============================================================
		// software accesses; after the engine so a set beats a clear
		if (acc_wr) begin
			unique case (ADDRESS)
				OFS_CONTROL_ONE: begin
					next_s.bc = WRITEDATA[CR1_BC_LSB +: 3];
					next_s.ack_en = WRITEDATA[CR1_ACK_BIT];
					next_s.sck = WRITEDATA[CR1_SCK_LSB +: 3];
				end
				OFS_CONTROL_TWO: begin
					next_s.master_select = WRITEDATA[CR2_MST_BIT];
					next_s.trx = WRITEDATA[CR2_TRX_BIT];
					next_s.sbim = WRITEDATA[CR2_SBIM_LSB +: 2];
					if (WRITEDATA[CR2_PIN_BIT]) begin
						next_s.pin = 1'b1;
					end
					if (WRITEDATA[CR2_MST_BIT -: 4] == CMD_START && !s.bb) begin
						next_s.start_req = 1'b1;
					end
					if (WRITEDATA[CR2_MST_BIT -: 4] == CMD_STOP && s.bb) begin
						next_s.stop_req = 1'b1;
					end
				end
				OFS_OWN_ADDRESS: begin
					next_s.sa = WRITEDATA[AR_SA_LSB +: 7];
					next_s.address_recognition_off = WRITEDATA[AR_ALS_BIT];
				end
				OFS_DATA_BUFFER: begin
					next_s.shift = WRITEDATA[7:0];
					next_s.pin = 1'b1;
					// a match in the same cycle keeps addressed set
					next_s.aas = aas_set;
				end
				default: begin
				end
			endcase
		end
		// read sets pending, clocks next word
		if (acc_rd && ADDRESS == OFS_DATA_BUFFER) begin
			next_s.pin = 1'b1;
			next_s.aas = aas_set;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			s <= '0;
			s.wait_req <= 1'b1;
			s.bc <= RST_BC;
			s.ack_en <= RST_ACK;
			s.sck <= RST_SCK;
			s.pin <= RST_PIN;
			s.sbim <= RST_SBIM;
			s.sa <= RST_SA;
			s.address_recognition_off <= RST_ALS;
			s.lrb <= 1'b1;
			s.mstate <= M_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// open drain: only the enables ever change
	assign SCL_O        = 1'b0;
	assign SDA_O        = 1'b0;
	assign SCL_OE       = s.scl_oe;
	assign SDA_OE       = s.sda_oe;
	assign READDATA     = s.rdata;
	assign WAITREQUEST  = s.wait_req;
	assign TRANSFER_IRQ = s.irq;

	// =================================================================
	// assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	property p_start;
		(s.mstate == M_IDLE && s.start_req && en) |=> (s.mstate == M_START && s.sda_oe
			&& !s.scl_oe);
	endproperty
	a_start: assert property (p_start) else $error("start not issued");

	property p_clocks;
		(s.mstate == M_HIGH) |-> (s.bit_cnt < total && (!s.addr_phase || total == 4'h9));
	endproperty
	a_clocks: assert property (p_clocks) else $error("clock count overrun");

	property p_master_hold;
		(s.mstate == M_WAIT && !s.pin) |-> s.scl_oe;
	endproperty
	a_master_hold: assert property (p_master_hold) else $error("scl not held");

	property p_master_irq;
		(s.irq && s.master_select) |-> (s.mstate == M_WAIT && !$past(s.irq));
	endproperty
	a_master_irq: assert property (p_master_irq) else $error("stray irq");

	property p_slave_ack;
		s.sl_ack |-> (s.sda_oe && s.aas);
	endproperty
	a_slave_ack: assert property (p_slave_ack) else $error("slave ack missing");

	property p_slave_hold;
		(s.sl_hold && !s.pin) |-> s.scl_oe;
	endproperty
	a_slave_hold: assert property (p_slave_hold) else $error("slave no stretch");

	property p_dbr_write;
		(acc_wr && ADDRESS == OFS_DATA_BUFFER) |=> s.pin;
	endproperty
	a_dbr_write: assert property (p_dbr_write) else $error("pending not set");

	property p_dbr_read;
		(acc_rd && ADDRESS == OFS_DATA_BUFFER && s.mstate == M_WAIT && !s.stop_req)
			|=> s.pin ##1 (s.mstate == M_LOW);
	endproperty
	a_dbr_read: assert property (p_dbr_read) else $error("read no clocks");

	property p_rx_ack;
		(s.mstate == M_LOW && !tx_mode && s.bit_cnt == nbits && $past(s.mstate) == M_LOW)
			|-> s.sda_oe;
	endproperty
	a_rx_ack: assert property (p_rx_ack) else $error("no receiver ack");

	property p_rx_release;
		(s.mstate == M_HIGH && !tx_mode && s.bit_cnt < nbits) |-> !s.sda_oe;
	endproperty
	a_rx_release: assert property (p_rx_release) else $error("receiver drove data");

	property p_pin_hold;
		(s.pin && !next_s.irq) |=> s.pin;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pending lost");

	property p_busy;
		(start_det |=> s.bb) and (stop_det && !start_det |=> !s.bb);
	endproperty
	a_busy: assert property (p_busy) else $error("busy flag wrong");

	c_start: cover property (s.mstate == M_START);
	c_master_irq: cover property (s.irq && s.master_select);
	c_slave_ack: cover property (s.sl_ack);
	c_stop: cover property (s.mstate == M_STOP2 ##1 s.mstate == M_IDLE);
endmodule // i2cseq_top
`default_nettype wire

// ### test/i2cseq_far_slave.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// far-side slave device on the two-wire bus
module i2cseq_far_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h2a // bus address answered
) (
	input  wire logic       scl,     // scl line level
	input  wire logic       sda,     // sda line level
	input  wire logic [7:0] tx_base, // first word returned on reads
	output logic            sda_low, // pull sda low
	output logic [7:0]      rx_byte, // last word written to us
	output logic            mack,    // master acked last read word
	output logic            nacked   // master ended the read
);
	logic       active;
	logic       in_addr;
	logic       rd;
	logic [7:0] sh;
	logic [7:0] tx;
	int         cnt;

	initial begin
		active = 1'b0;
		in_addr = 1'b0;
		rd = 1'b0;
		sh = 8'h00;
		tx = 8'h00;
		cnt = 0;
		sda_low = 1'b0;
		rx_byte = 8'h00;
		mack = 1'b0;
		nacked = 1'b0;
	end

	// =================================================================
	// conditions: only sda moving while scl is high
	always @(negedge sda) if (scl === 1'b1) begin
		active = 1'b1;
		in_addr = 1'b1;
		cnt = 0;
		nacked = 1'b0;
	end
	always @(posedge sda) if (scl === 1'b1) begin
		active = 1'b0;
		sda_low = 1'b0;
	end

	// =================================================================
	// bit engine; ninth rise of a read word carries the master's answer
	always @(posedge scl) if (active) begin
		if (cnt < 8)
			sh = {sh[6:0], sda};
		else if (rd && !in_addr) begin
			mack = !sda;
			nacked = sda;
		end
		cnt++;
	end
	// data only changes while scl is low
	always @(negedge scl) if (active) begin
		if (cnt == 8) begin
			if (in_addr) begin
				rd = sh[0];
				tx = tx_base;
				sda_low = (sh[7:1] == DEV_ADDR);
				active = sda_low;
			end else
				sda_low = !rd;
			if (!in_addr && !rd)
				rx_byte = sh;
		end else if (cnt == 9) begin
			if (rd && !in_addr)
				tx = tx + 8'h01;
			in_addr = 1'b0;
			cnt = 0;
			sda_low = rd && !nacked && !tx[7];
			active = !nacked;
		end else if (rd && !in_addr)
			sda_low = !tx[7 - cnt];
	end
endmodule // i2cseq_far_slave
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// bench top
module tb;
	import i2cseq_pkg::*;
	// low 7 cycles, high 7 plus 2 sync cycles: a 160 ns scl period
	localparam int         HALF = 7;
	localparam logic [6:0] SLV  = 7'h2a;
	localparam logic [7:0] TXB  = 8'h96;

	logic        CLK;
	logic        SYS_RST;
	logic [4:0]  ADDRESS;
	logic        READ;
	logic        WRITE;
	logic [31:0] WRITEDATA;
	logic [31:0] READDATA;
	logic        WAITREQUEST;
	logic        SCL_O;
	logic        SCL_OE;
	logic        SDA_O;
	logic        SDA_OE;
	logic        TRANSFER_IRQ;
	logic        sda_low;
	logic [7:0]  rx_byte;
	logic        mack;
	logic        nacked;
	logic        fm_scl_low;
	logic        fm_sda_low;
	logic [31:0] q;
	wire logic   scl_line;
	wire logic   sda_line;
	int          err_total;
	int          n_checks;
	int          nrise;

	// open-drain lines with pull-ups
	assign scl_line = (SCL_OE ? SCL_O : 1'b1) & ~fm_scl_low;
	assign sda_line = (SDA_OE ? SDA_O : 1'b1) & ~sda_low & ~fm_sda_low;

	i2cseq_top #(.SCL_HALF_BASE(HALF)) dut (
		.CLK(CLK), .SYS_RST(SYS_RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
		.WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
		.SCL_I(scl_line), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(sda_line),
		.SDA_O(SDA_O), .SDA_OE(SDA_OE), .TRANSFER_IRQ(TRANSFER_IRQ)
	);

	i2cseq_far_slave #(.DEV_ADDR(SLV)) far (
		.scl(scl_line), .sda(sda_line), .tx_base(TXB), .sda_low(sda_low),
		.rx_byte(rx_byte), .mack(mack), .nacked(nacked)
	);

	always #5 CLK = ~CLK;
	always @(posedge scl_line) nrise++;

	// =================================================================
	// reporting
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic fail_out();
		err_total++;
		$display("FAIL %0t: timeout", $time);
		final_report();
	endtask

	// =================================================================
	// avalon master: hold until waitrequest is seen low
	task automatic bus(input logic wr_en, input logic [4:0] a, input logic [7:0] d);
		int i;
		@(posedge CLK);
		ADDRESS <= a;
		WRITEDATA <= {24'h0, d};
		WRITE <= wr_en;
		READ <= !wr_en;
		i = 0;
		do begin
			@(posedge CLK);
			i++;
		end while (WAITREQUEST !== 1'b0 && i < 100);
		if (i >= 100)
			fail_out();
		q = READDATA;
		WRITE <= 1'b0;
		READ <= 1'b0;
	endtask

	// bench acting as a far master; one line moves per call
	task automatic fm(input logic c_low, input logic d_low);
		@(posedge CLK);
		fm_scl_low <= c_low;
		fm_sda_low <= d_low;
		repeat (9) @(posedge CLK);
	endtask

	task automatic wait_irq();
		int i;
		i = 0;
		while (TRANSFER_IRQ !== 1'b1 && i < 5000) begin
			@(posedge CLK);
			i++;
		end
		if (i >= 5000)
			fail_out();
	endtask

	// =================================================================
	// scenarios
	task automatic t_reset_regs();
		logic [4:0] offs [5];
		logic [7:0] exps [5];
		offs = '{OFS_CONTROL_ONE, OFS_CONTROL_TWO, OFS_OWN_ADDRESS, OFS_BUS_STATUS, 5'h14};
		exps = '{8'h00, 8'h10, 8'h00, 8'h11, 8'h00};
		bus(1'b1, 5'h14, 8'hff);
		for (int k = 0; k < 5; k++) begin
			bus(1'b0, offs[k], 8'h00);
			chk(q, {24'h0, exps[k]});
		end
	endtask

	task automatic t_init();
		bus(1'b1, OFS_CONTROL_ONE, 8'h10);
		bus(1'b1, OFS_OWN_ADDRESS, {7'h11, 1'b0});
		chk({30'h0, scl_line, sda_line}, 32'h3);
		bus(1'b1, OFS_CONTROL_TWO, 8'h18);
		bus(1'b0, OFS_CONTROL_TWO, 8'h00);
		chk(q, 32'h18);
		bus(1'b1, OFS_CONTROL_TWO, 8'h08);
		bus(1'b0, OFS_BUS_STATUS, 8'h00);
		chk({31'h0, q[4]}, 32'h1);
	endtask

	task automatic t_addr(input logic dir);
		bus(1'b0, OFS_BUS_STATUS, 8'h00);
		chk({31'h0, q[5]}, 32'h0);
		bus(1'b1, OFS_DATA_BUFFER, {SLV, dir});
		nrise = 0;
		bus(1'b1, OFS_CONTROL_TWO, 8'hf8);
		wait_irq();
		chk(32'(nrise), 32'd9);
		bus(1'b0, OFS_BUS_STATUS, 8'h00);
		chk(q, dir ? 32'ha0 : 32'he0);
		repeat (40) @(posedge CLK);
		chk({31'h0, scl_line}, 32'h0);
	endtask

	task automatic t_stop();
		int i;
		bus(1'b1, OFS_CONTROL_TWO, 8'hd8);
		i = 0;
		do begin
			bus(1'b0, OFS_BUS_STATUS, 8'h00);
			i++;
		end while (q[5] !== 1'b0 && i < 60);
		chk({31'h0, q[5]}, 32'h0);
		chk({30'h0, scl_line, sda_line}, 32'h3);
	endtask

	task automatic t_write_word();
		bus(1'b0, OFS_BUS_STATUS, 8'h00);
		chk({30'h0, q[7:6]}, 32'h3);
		chk({31'h0, q[0]}, 32'h0);
		nrise = 0;
		bus(1'b1, OFS_DATA_BUFFER, 8'hc3);
		wait_irq();
		chk({24'h0, rx_byte}, 32'hc3);
		chk(32'(nrise), 32'd9);
		bus(1'b0, OFS_BUS_STATUS, 8'h00);
		chk(q, 32'he0);
	endtask

	task automatic t_read_words();
		t_addr(1'b1);
		nrise = 0;
		bus(1'b0, OFS_DATA_BUFFER, 8'h00);
		wait_irq();
		chk(32'(nrise), 32'd9);
		chk({31'h0, mack}, 32'h1);
		// no ack clock for last word
		bus(1'b1, OFS_CONTROL_ONE, 8'h00);
		nrise = 0;
		bus(1'b0, OFS_DATA_BUFFER, 8'h00);
		chk(q, {24'h0, TXB});
		wait_irq();
		chk(32'(nrise), 32'd8);
		bus(1'b1, OFS_CONTROL_ONE, 8'h20);
		nrise = 0;
		bus(1'b0, OFS_DATA_BUFFER, 8'h00);
		chk(q, {24'h0, TXB + 8'h01});
		wait_irq();
		chk(32'(nrise), 32'd1);
		chk({31'h0, nacked}, 32'h1);
	endtask

	task automatic t_slave_addr();
		logic [7:0] a;
		a = {7'h11, 1'b0};
		fm(1'b0, 1'b1);
		for (int k = 7; k >= 0; k--) begin
			fm(1'b1, fm_sda_low);
			fm(1'b1, !a[k]);
			fm(1'b0, !a[k]);
		end
		fm(1'b1, fm_sda_low);
		fm(1'b1, 1'b0);
		fm(1'b0, 1'b0);
		chk({31'h0, sda_line}, 32'h0);
		@(posedge CLK);
		fm_scl_low <= 1'b1;
		wait_irq();
		@(posedge CLK);
		fm_scl_low <= 1'b0;
		repeat (20) @(posedge CLK);
		chk({31'h0, scl_line}, 32'h0);
		bus(1'b0, OFS_BUS_STATUS, 8'h00);
		chk(q & 32'hfe, 32'h24);
		bus(1'b0, OFS_DATA_BUFFER, 8'h00);
		repeat (10) @(posedge CLK);
		chk({31'h0, scl_line}, 32'h1);
		fm(1'b1, 1'b0);
		fm(1'b1, 1'b1);
		fm(1'b0, 1'b1);
		fm(1'b0, 1'b0);
		bus(1'b0, OFS_BUS_STATUS, 8'h00);
		chk({31'h0, q[5]}, 32'h0);
	endtask

	// =================================================================
	// main sequence
	initial begin
		CLK = 1'b0;
		SYS_RST = 1'b1;
		ADDRESS = 5'h00;
		READ = 1'b0;
		WRITE = 1'b0;
		WRITEDATA = 32'h0;
		fm_scl_low = 1'b0;
		fm_sda_low = 1'b0;
		err_total = 0;
		n_checks = 0;
		nrise = 0;
		repeat (20) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		t_reset_regs();
		t_init();
		t_addr(1'b0);
		t_write_word();
		t_stop();
		t_read_words();
		t_stop();
		t_slave_addr();
		final_report();
	end
endmodule // tb
`default_nettype wire
